// [shared/lbudc_pkg.sv]
// constants for the local bus user logic with dma requests and user clock
// assumes one 200 MHz clock and a bridge acting as local bus master
package lbudc_pkg;
  // ==========================================================
  // address map inside the user memory window
  localparam logic [20:0] OFS_TTL_DATA = 21'h008008;
  localparam logic [20:0] OFS_TTL_DIR = 21'h008010;
  localparam logic [20:0] OFS_DMA_CTL = 21'h008028;
  localparam logic [20:0] OFS_DMA_SIZE0 = 21'h00802c;
  localparam logic [20:0] OFS_DMA_SIZE1 = 21'h008030;
  localparam logic [20:0] SRAM_BASE = 21'h100000;
  localparam logic [20:0] SRAM_LAST = 21'h1fffff;
  localparam int SRAM_SEL_BIT = 20;
  // ==========================================================
  // widths and field positions
  localparam int BUS_DW = 32;
  localparam int SRAM_AW = 18;
  localparam int SRAM_DW = 36;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = SRAM_AW + 4 + BUS_DW;
  localparam int SIZE_W = 18;
  localparam logic [31:0] SIZE_MAX = 32'h00003fff;
  localparam int CTL_CH0 = 0;
  localparam int CTL_CH1 = 1;
  localparam int CTL_CLKSEL = 8;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic [15:0] RST_TTL = 16'h0000;
  localparam logic [31:0] RST_SIZE = 32'h00000000;
  // ==========================================================
  // timing
  localparam int SRAM_LAT = 2;
  localparam longint MCLK_HZ = 200000000;
  localparam longint UCLK_HZ = 50000000;
  localparam longint UCLK_MIN_HZ = 10000000;
  localparam longint UCLK_MAX_HZ = 100000000;
  localparam int UCLK_HALF = int'(MCLK_HZ / (2 * UCLK_HZ));
  localparam logic [3:0] UCLK_HALF_M1 = 4'(UCLK_HALF - 1);
endpackage

// [logic/lbudc_top.sv]
// local bus target, sram window, demand dma requests, user clock, ttl pads
// assumes the bridge is local master and all inputs are synchronous to MCLK_I
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// fifo
module lbudc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // clock
  input wire logic rst_i, // sync reset
  input wire logic in_valid_i, // push request
  output logic in_ready_o, // not full
  input wire logic [WIDTH-1:0] in_data_i, // push data
  output logic out_valid_o, // not empty
  input wire logic out_ready_i, // pop request
  output logic [WIDTH-1:0] out_data_o // head word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lbudc_fifo_state_t;
  lbudc_fifo_state_t q, next_q;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  always_comb
  begin
    in_ready_o = (q.wp - q.rp) != (AW+1)'(DEPTH);
    out_valid_o = q.wp != q.rp;
    out_data_o = mem[q.rp[AW-1:0]];
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_q = q;
    if (push)
    begin
      next_q.wp = q.wp + 1'b1;
    end
    if (pop)
    begin
      next_q.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
    if (push)
    begin
      mem[q.wp[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ==========================================================
// top
module lbudc_top (
  input wire logic MCLK_I, // board clock
  input wire logic SRST_I, // sync reset, high
  input wire logic LOCAL_ADDRESS_STROBE_N_I, // one per data cycle
  input wire logic [20:2] LADDR_I, // word address in window
  input wire logic [3:0] LBE_N_I, // byte enables, low
  input wire logic LWNR_I, // 1 write, 0 read
  input wire logic [31:0] LD_I, // write data
  output logic [31:0] LD_O, // read data
  output logic LD_OE_O, // data bus drive
  output logic LREADY_N_O, // transfer done, low
  output logic LOCAL_BUS_BACKOFF_REQUEST_O, // bus takeover request
  output logic DMA_REQUEST_CH0_N_O, // channel 0 demand
  output logic DMA_REQUEST_CH1_N_O, // channel 1 demand
  input wire logic BRIDGE_USER_OUTPUT_CLOCK_SELECT_I, // 1 crystal, 0 user clock
  output logic USER_CLK_O, // generated user clock
  output logic [17:0] SRAM_A_O, // sram address
  output logic SRAM_CE_N_O, // sram cycle, low
  output logic SRAM_WE_N_O, // sram write, low
  output logic [3:0] SRAM_BW_N_O, // sram byte writes, low
  input wire logic [35:0] SRAM_D_I, // sram read data
  output logic [35:0] SRAM_D_O, // sram write data
  output logic SRAM_D_OE_O, // sram data drive
  input wire logic [15:0] TTL_I, // ttl pad levels
  output logic [15:0] TTL_O, // ttl pad value
  output logic [15:0] TTL_OE_O // ttl pad pulls low
);
  typedef enum logic [2:0] {S_IDLE, S_REG, S_WPUSH, S_RWAIT, S_RPIPE, S_DONE} lbudc_st_t;
  typedef struct packed {
    lbudc_st_t st;
    logic [20:2] addr;
    logic wr;
    logic [3:0] be_n;
    logic lready;
    logic [31:0] ld;
    logic ld_oe;
    logic backoff;
    logic [7:0] dir;
    logic [15:0] ttl_data;
    logic [15:0] ttl_oe;
    logic [15:0] ttl_o;
    logic [1:0] ctl;
    logic [31:0] size0;
    logic [31:0] size1;
    logic [17:0] rem0;
    logic [17:0] rem1;
    logic [1:0] dreq_n;
    logic [17:0] sa;
    logic sce_n;
    logic swe_n;
    logic [3:0] sbw_n;
    logic sw0;
    logic sw1;
    logic [31:0] wd0;
    logic [31:0] wd1;
    logic [35:0] sdo;
    logic sdoe;
    logic rs0;
    logic rs1;
    logic rs2;
    logic [3:0] div;
    logic uclk;
  } lbudc_state_t;
  lbudc_state_t q, next_q;

  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [lbudc_pkg::FIFO_W-1:0] fifo_out_data;
  logic [20:0] byte_addr;

  function automatic logic [31:0] lbudc_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0] be_n);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (!be_n[i])
      begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // write buffer towards the sram; a full buffer stalls the bus ready
  lbudc_fifo #(
    .WIDTH(lbudc_pkg::FIFO_W),
    .DEPTH(lbudc_pkg::FIFO_DEPTH)
  ) i_lbudc_fifo (
    .clk_i(MCLK_I),
    .rst_i(SRST_I),
    .in_valid_i(q.st == S_WPUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i({q.addr[19:2], q.be_n, LD_I}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  assign byte_addr = {q.addr, 2'b00};
  // no write may start while a read owns the sram data bus
  assign fifo_out_ready = !(q.rs0 || q.rs1 || q.rs2);

  always_comb
  begin
    logic issue;
    logic [31:0] merged;
    issue = 1'b0;
    merged = lbudc_merge({30'h0, q.ctl}, LD_I, q.be_n);
    next_q = q;
    next_q.lready = 1'b0;
    next_q.sce_n = 1'b1;
    next_q.swe_n = 1'b1;
    next_q.sbw_n = 4'hf;
    next_q.backoff = 1'b0;
    next_q.ttl_o = '0;
    // ----- sram pipeline: address at t, data at t+2
    next_q.sw1 = q.sw0;
    next_q.wd1 = q.wd0;
    next_q.sw0 = 1'b0;
    next_q.sdoe = q.sw1;
    next_q.sdo = {4'h0, q.wd1};
    next_q.rs1 = q.rs0;
    next_q.rs2 = q.rs1;
    next_q.rs0 = 1'b0;
    if (fifo_out_valid && fifo_out_ready)
    begin
      issue = 1'b1;
      next_q.sce_n = 1'b0;
      next_q.swe_n = 1'b0;
      next_q.sa = fifo_out_data[53:36];
      next_q.sbw_n = fifo_out_data[35:32];
      next_q.sw0 = 1'b1;
      next_q.wd0 = fifo_out_data[31:0];
    end
    // ----- local bus target
    case (q.st)
      S_IDLE:
      begin
        if (!LOCAL_ADDRESS_STROBE_N_I)
        begin
          next_q.addr = LADDR_I;
          next_q.wr = LWNR_I;
          next_q.be_n = LBE_N_I;
          if (!LADDR_I[lbudc_pkg::SRAM_SEL_BIT])
          begin
            next_q.st = S_REG;
          end
          else
          begin
            next_q.st = LWNR_I ? S_WPUSH : S_RWAIT;
          end
        end
      end
      S_REG:
      begin
        next_q.lready = 1'b1;
        next_q.ld_oe = !q.wr;
        next_q.st = S_DONE;
        next_q.ld = '0;
        case (byte_addr)
          lbudc_pkg::OFS_TTL_DATA:
          begin
            next_q.ld = {16'h0000, TTL_I};
            if (q.wr)
            begin
              next_q.ttl_data = 16'(lbudc_merge({16'h0000, q.ttl_data}, LD_I, q.be_n));
            end
          end
          lbudc_pkg::OFS_TTL_DIR:
          begin
            next_q.ld = {24'h000000, q.dir};
            if (q.wr)
            begin
              next_q.dir = 8'(lbudc_merge({24'h000000, q.dir}, LD_I, q.be_n));
            end
          end
          lbudc_pkg::OFS_DMA_CTL:
          begin
            next_q.ld = {23'h000000, BRIDGE_USER_OUTPUT_CLOCK_SELECT_I, 6'h00, q.ctl};
            if (q.wr)
            begin
              next_q.ctl = merged[1:0];
            end
          end
          lbudc_pkg::OFS_DMA_SIZE0:
          begin
            next_q.ld = q.size0;
            if (q.wr)
            begin
              next_q.size0 = lbudc_merge(q.size0, LD_I, q.be_n);
            end
          end
          lbudc_pkg::OFS_DMA_SIZE1:
          begin
            next_q.ld = q.size1;
            if (q.wr)
            begin
              next_q.size1 = lbudc_merge(q.size1, LD_I, q.be_n);
            end
          end
          default:
          begin
            next_q.ld = '0;
          end
        endcase
      end
      S_WPUSH:
      begin
        if (fifo_in_ready)
        begin
          next_q.lready = 1'b1;
          next_q.st = S_DONE;
        end
      end
      S_RWAIT:
      begin
        // reads wait behind buffered writes so they see fresh data
        if (!fifo_out_valid && !q.sw0 && !q.sw1 && !q.sdoe)
        begin
          issue = 1'b1;
          next_q.sce_n = 1'b0;
          next_q.sa = q.addr[19:2];
          next_q.rs0 = 1'b1;
          next_q.st = S_RPIPE;
        end
      end
      S_RPIPE:
      begin
        if (q.rs2)
        begin
          next_q.ld = SRAM_D_I[31:0];
          next_q.ld_oe = 1'b1;
          next_q.lready = 1'b1;
          next_q.st = S_DONE;
        end
      end
      S_DONE:
      begin
        next_q.ld_oe = 1'b0;
        next_q.st = S_IDLE;
      end
      default:
      begin
        next_q.st = S_IDLE;
      end
    endcase
    // ----- demand dma: load on request, count moved long words
    if (next_q.ctl[0] && !q.ctl[0])
    begin
      next_q.rem0 = 18'(q.size0 & lbudc_pkg::SIZE_MAX);
    end
    else if (issue && q.ctl[0] && q.rem0 != '0)
    begin
      next_q.rem0 = q.rem0 - 1'b1;
    end
    if (next_q.ctl[1] && !q.ctl[1])
    begin
      next_q.rem1 = 18'(q.size1 & lbudc_pkg::SIZE_MAX);
    end
    else if (issue && q.ctl[1] && q.rem1 != '0 && !(q.ctl[0] && q.rem0 != '0))
    begin
      next_q.rem1 = q.rem1 - 1'b1;
    end
    // a set by software in the same cycle wins over the completion clear
    if (q.ctl[0] && q.rem0 == '0 && !(q.st == S_REG && q.wr && byte_addr ==
        lbudc_pkg::OFS_DMA_CTL && merged[0]))
    begin
      next_q.ctl[0] = 1'b0;
    end
    if (q.ctl[1] && q.rem1 == '0 && !(q.st == S_REG && q.wr && byte_addr ==
        lbudc_pkg::OFS_DMA_CTL && merged[1]))
    begin
      next_q.ctl[1] = 1'b0;
    end
    next_q.dreq_n[0] = !(next_q.ctl[0] && next_q.rem0 != '0);
    next_q.dreq_n[1] = !(next_q.ctl[1] && next_q.rem1 != '0);
    // ----- open drain ttl: pad pulls low only for an output bit of zero
    for (int i = 0; i < 16; i++)
    begin
      next_q.ttl_oe[i] = next_q.dir[i/2] && !next_q.ttl_data[i];
    end
    // ----- user clock, 200/4 = 50 MHz, inside the 10..100 MHz band
    if (q.div == lbudc_pkg::UCLK_HALF_M1)
    begin
      next_q.div = '0;
      next_q.uclk = !q.uclk;
    end
    else
    begin
      next_q.div = q.div + 1'b1;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      q <= '0;
      q.st <= S_IDLE;
      q.dir <= lbudc_pkg::RST_DIR;
      q.ttl_data <= lbudc_pkg::RST_TTL;
      q.size0 <= lbudc_pkg::RST_SIZE;
      q.size1 <= lbudc_pkg::RST_SIZE;
      q.dreq_n <= 2'h3;
      q.sce_n <= 1'b1;
      q.swe_n <= 1'b1;
      q.sbw_n <= 4'hf;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign LD_O = q.ld;
  assign LD_OE_O = q.ld_oe;
  assign LREADY_N_O = !q.lready;
  assign LOCAL_BUS_BACKOFF_REQUEST_O = q.backoff;
  assign DMA_REQUEST_CH0_N_O = q.dreq_n[0];
  assign DMA_REQUEST_CH1_N_O = q.dreq_n[1];
  assign USER_CLK_O = q.uclk;
  assign SRAM_A_O = q.sa;
  assign SRAM_CE_N_O = q.sce_n;
  assign SRAM_WE_N_O = q.swe_n;
  assign SRAM_BW_N_O = q.sbw_n;
  assign SRAM_D_O = q.sdo;
  assign SRAM_D_OE_O = q.sdoe;
  assign TTL_O = q.ttl_o;
  assign TTL_OE_O = q.ttl_oe;

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_strobe;
    q.st == S_IDLE && !LOCAL_ADDRESS_STROBE_N_I;
  endsequence
  sequence s_sram_rd;
    !SRAM_CE_N_O && SRAM_WE_N_O;
  endsequence
  sequence s_size0_wr;
    q.st == S_REG && q.wr && byte_addr == lbudc_pkg::OFS_DMA_SIZE0 && q.be_n == 4'h0;
  endsequence

  bus_ready_a: assert property (s_strobe |-> ##[2:60] !LREADY_N_O)
    else $error("no ready after address strobe");
  ready_pulse_a: assert property (!LREADY_N_O |=> LREADY_N_O)
    else $error("ready longer than one cycle");
  size_store_a: assert property (s_size0_wr |=> q.size0 == $past(LD_I))
    else $error("size register not written");
  sram_read_a: assert property (s_sram_rd |-> ##2 q.rs2 ##1 !LREADY_N_O && LD_OE_O)
    else $error("sram read not returned after latency");
  sram_write_a: assert property (!SRAM_CE_N_O && !SRAM_WE_N_O |-> ##2 SRAM_D_OE_O
    && SRAM_D_O[35:32] == 4'h0)
    else $error("sram write data not driven");
  dma_start_a: assert property ($rose(q.ctl[0]) && q.rem0 != '0 |-> !DMA_REQUEST_CH0_N_O)
    else $error("channel 0 request not asserted");
  dma_end_a: assert property (q.ctl[1] && q.rem1 == '0 && q.st != S_REG
    |=> DMA_REQUEST_CH1_N_O && !q.ctl[1])
    else $error("channel 1 request not released");
  backoff_low_a: assert property (LOCAL_BUS_BACKOFF_REQUEST_O == 1'b0)
    else $error("backoff request driven");
  ttl_reset_a: assert property (@(posedge MCLK_I) disable iff (1'b0) SRST_I |=> TTL_OE_O == '0)
    else $error("ttl pad driven after reset");
  ttl_drain_a: assert property (|TTL_OE_O |-> |q.dir && TTL_O == '0)
    else $error("ttl pad not open drain");
  uclk_half_a: assert property ($changed(USER_CLK_O) |=> $stable(USER_CLK_O))
    else $error("user clock half period too short");
endmodule
`default_nettype wire

// [sim/lbudc_far_model.sv]
// bridge-side model: local bus master task and a pipelined sram
// assumes one board clock shared with the block; bus inputs move at falling edges
`timescale 1ns/1ps
`default_nettype none

module lbudc_far_model (
  input wire logic clk_i, // board clock
  input wire logic ready_n_i, // transfer done, low
  output logic strobe_n_o, // address strobe, low
  output logic [20:2] addr_o, // word address
  output logic [3:0] be_n_o, // byte enables, low
  output logic wnr_o, // 1 write, 0 read
  output logic [31:0] wdata_o, // write data
  input wire logic [17:0] sram_a_i, // sram address
  input wire logic sram_ce_n_i, // sram cycle, low
  input wire logic sram_we_n_i, // sram write, low
  input wire logic [3:0] sram_bw_n_i, // byte writes, low
  input wire logic [35:0] sram_d_i, // write data from block
  input wire logic sram_d_oe_i, // block drives data
  output logic [35:0] sram_q_o // read data to block
);
  logic rd;
  logic [23:0] p1;
  logic [23:0] p2;
  logic [35:0] mem [int];
  int timeouts = 0;

  initial
  begin
    rd = 1'b0;
    strobe_n_o = 1'b1;
    addr_o = '0;
    be_n_o = 4'hf;
    wnr_o = 1'b0;
    wdata_o = 32'h0;
    p1 = '0;
    p2 = '0;
    sram_q_o = '0;
  end

  // ==========================================================
  // single-cycle master: one strobe per data cycle, bursts never used
  task automatic access(input logic wr, input logic [20:0] a, input logic [3:0] be_n,
                        input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk_i);
    rd = !wr;
    strobe_n_o = 1'b0;
    addr_o = a[20:2];
    be_n_o = be_n;
    wnr_o = wr;
    @(negedge clk_i);
    strobe_n_o = 1'b1;
    wdata_o = wr ? d : ~wdata_o;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ready_n_i !== 1'b0 && n < 300);
    if (ready_n_i !== 1'b0)
    begin
      timeouts++;
    end
    @(negedge clk_i);
    // released data bus must not look like the last value
    wdata_o = ~wdata_o;
    @(negedge clk_i);
  endtask

  // ==========================================================
  // sram: command cycle, data two cycles later
  always @(posedge clk_i)
  begin
    if (sram_d_oe_i && p2[23] && p2[22])
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!p2[18+i])
        begin
          mem[int'(p2[17:0])][8*i+:8] = sram_d_i[8*i+:8];
        end
      end
    end
    if (p1[23] && !p1[22] && mem.exists(int'(p1[17:0])))
      sram_q_o <= mem[int'(p1[17:0])];
    else
      sram_q_o <= ~sram_q_o;
    p1 <= {~sram_ce_n_i, ~sram_we_n_i, sram_bw_n_i, sram_a_i};
    p2 <= p1;
  end
endmodule

`default_nettype wire

// [sim/local_bus_user_logic_dma_clock_tb.sv]
// self-checking bench for the local bus target with dma requests and user clock
// assumes lbudc_pkg compiled first and the far model driving bus and sram
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end

module local_bus_user_logic_dma_clock_tb;
  logic mclk = 1'b0;
  logic srst, strobe_n, lwnr, ready_n, backoff, req0_n, req1_n, clksel, uclk, ld_oe;
  logic sram_ce_n, sram_we_n, sram_d_oe;
  logic [20:2] laddr;
  logic [3:0] lbe_n, sram_bw_n;
  logic [31:0] ld_i, ld_o, e;
  logic [17:0] sram_a;
  logic [35:0] sram_q, sram_d;
  logic [15:0] ttl_i, ttl_o, ttl_oe;
  logic [31:0] exp_q [$];
  int err_total = 0;
  int n_checks = 0;

  always #2.5 mclk = ~mclk;

  lbudc_top i_lbudc_top (.MCLK_I(mclk), .SRST_I(srst), .LOCAL_ADDRESS_STROBE_N_I(strobe_n),
    .LADDR_I(laddr), .LBE_N_I(lbe_n), .LWNR_I(lwnr), .LD_I(ld_i), .LD_O(ld_o),
    .LD_OE_O(ld_oe),
    .LREADY_N_O(ready_n), .LOCAL_BUS_BACKOFF_REQUEST_O(backoff), .DMA_REQUEST_CH0_N_O(req0_n),
    .DMA_REQUEST_CH1_N_O(req1_n), .BRIDGE_USER_OUTPUT_CLOCK_SELECT_I(clksel),
    .USER_CLK_O(uclk), .SRAM_A_O(sram_a), .SRAM_CE_N_O(sram_ce_n), .SRAM_WE_N_O(sram_we_n),
    .SRAM_BW_N_O(sram_bw_n), .SRAM_D_I(sram_q), .SRAM_D_O(sram_d), .SRAM_D_OE_O(sram_d_oe),
    .TTL_I(ttl_i), .TTL_O(ttl_o), .TTL_OE_O(ttl_oe));

  lbudc_far_model i_lbudc_far_model (.clk_i(mclk), .ready_n_i(ready_n), .strobe_n_o(strobe_n),
    .addr_o(laddr), .be_n_o(lbe_n), .wnr_o(lwnr), .wdata_o(ld_i), .sram_a_i(sram_a),
    .sram_ce_n_i(sram_ce_n), .sram_we_n_i(sram_we_n), .sram_bw_n_i(sram_bw_n),
    .sram_d_i(sram_d), .sram_d_oe_i(sram_d_oe), .sram_q_o(sram_q));

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wr(input logic [20:0] a, input logic [3:0] b, input logic [31:0] d);
    i_lbudc_far_model.access(1'b1, a, b, d);
  endtask

  // expected read data goes on the queue before the request
  task automatic rd(input logic [20:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    i_lbudc_far_model.access(1'b0, a, 4'h0, 32'h0);
  endtask

  // ==========================================================
  // monitor: each read completion takes the oldest note
  always @(posedge mclk)
  begin
    if (ready_n === 1'b0 && i_lbudc_far_model.rd === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK(ld_o, e)
      `CHK(ld_oe, 1'b1)
    end
    else if (ready_n === 1'b0)
    begin
      `CHK(ld_oe, 1'b0)
    end
  end

  // ==========================================================
  // watchdog, well beyond the sequence length
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    logic [20:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] b;
    time t0;
    void'($urandom(83249));
    srst = 1'b1;
    clksel = 1'b1;
    ttl_i = 16'h0;
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    ttl_i = 16'($urandom());
    `CHK(ttl_oe, 16'h0000)
    `CHK(backoff, 1'b0)
    `CHK({req1_n, req0_n}, 2'b11)
    wr(lbudc_pkg::OFS_DMA_SIZE0, 4'h0, 32'h00003fff);
    rd(lbudc_pkg::OFS_DMA_SIZE0, 32'h00003fff);
    wr(lbudc_pkg::OFS_DMA_SIZE1, 4'h0, 32'h00002a5c);
    wr(lbudc_pkg::OFS_DMA_SIZE1, 4'he, 32'h000000c3);
    wr(lbudc_pkg::OFS_DMA_SIZE1, 4'hd, 32'h00001100);
    rd(lbudc_pkg::OFS_DMA_SIZE1, 32'h000011c3);
    rd(21'h008100, 32'h0);
    // sram: full write, one-byte merge, read straight behind the buffered writes
    for (int k = 0; k < 6; k++)
    begin
      a = (k == 0) ? 21'h1ffffc : {1'b1, 18'($urandom()), 2'b00};
      d = $urandom();
      m = $urandom();
      b = 2'($urandom());
      wr(a, 4'h0, d);
      wr(a, ~(4'h1 << b), m);
      d[8*b+:8] = m[8*b+:8];
      rd(a, d);
    end
    clksel = 1'b0;
    rd(lbudc_pkg::OFS_DMA_CTL, 32'h0);
    clksel = 1'b1;
    rd(lbudc_pkg::OFS_DMA_CTL, 32'h100);
    wr(lbudc_pkg::SRAM_BASE, 4'h0, 32'h0);
    // demand dma: channel 0 moves 3 words, channel 1 moves 2
    for (int ch = 0; ch < 2; ch++)
    begin
      wr(ch ? lbudc_pkg::OFS_DMA_SIZE1 : lbudc_pkg::OFS_DMA_SIZE0, 4'h0, 32'(3 - ch));
      wr(lbudc_pkg::OFS_DMA_CTL, 4'h0, 32'(1 << ch));
      repeat (2) @(negedge mclk);
      `CHK({req1_n, req0_n}, ~2'(1 << ch))
      repeat (2 - ch) wr(lbudc_pkg::SRAM_BASE, 4'h0, 32'h0);
      `CHK({req1_n, req0_n}, ~2'(1 << ch))
      rd(lbudc_pkg::SRAM_BASE, 32'h0);
      repeat (4) @(negedge mclk);
      `CHK({req1_n, req0_n}, 2'b11)
      rd(lbudc_pkg::OFS_DMA_CTL, 32'h100);
    end
    wr(lbudc_pkg::OFS_DMA_SIZE0, 4'h0, 32'h0);
    wr(lbudc_pkg::OFS_DMA_CTL, 4'h0, 32'h1);
    repeat (2) @(negedge mclk);
    `CHK({req1_n, req0_n}, 2'b11)
    rd(lbudc_pkg::OFS_DMA_CTL, 32'h100);
    // ttl pads: only pads of an output pair whose own data bit is zero pull low
    wr(lbudc_pkg::OFS_TTL_DATA, 4'h0, 32'h0);
    `CHK(ttl_oe, 16'h0000)
    wr(lbudc_pkg::OFS_TTL_DIR, 4'h0, 32'h1);
    `CHK(ttl_oe, 16'h0003)
    wr(lbudc_pkg::OFS_TTL_DATA, 4'h0, 32'h0000fffe);
    `CHK(ttl_oe, 16'h0001)
    `CHK(ttl_o, 16'h0000)
    rd(lbudc_pkg::OFS_TTL_DATA, {16'h0000, ttl_i});
    rd(lbudc_pkg::OFS_TTL_DIR, 32'h00000001);
    @(posedge uclk);
    t0 = $time;
    @(posedge uclk);
    `CHK(64'($time - t0), 64'(1000000000 / lbudc_pkg::UCLK_HZ))
    // second reset in mid-run returns the pads to inputs
    @(negedge mclk);
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    `CHK(ttl_oe, 16'h0000)
    `CHK({req1_n, req0_n}, 2'b11)
    `CHK(exp_q.size(), 0)
    `CHK(i_lbudc_far_model.timeouts, 0)
    wrap_up();
  end
endmodule

`default_nettype wire
